// [verilog/host_bus_arbiter.sv]
`timescale 1ns/100ps
// Operation
// - Core off: request pin is open-drain DMA request
// - Grant announces release at cycle end
// - Core off: grant pin is DMA input
// - During reset grant follows request
// - Drive grant-ack while a DMA channel owns bus
// - Grant-ack stays continuous across SERIAL_DMA_CHANNEL cycle steal
// - Normal mode: encoded level, 7 nonmaskable, 0 none
// - Dedicated mode: direct requests at 1, 6, 7
// - Levels 1, 6 level/edge; 7 edge only
// - Cycle codes driven only when master
// - Core codes fixed, DMA codes programmable
// - Autovector replaces transfer ack in acknowledge
// - Core off: autovector pin is lowest irq output
// - Core off: request, grant swap; release-demand two-way
// - Transfer ack output only when generated internally
// - Bus fault on watchdog, conflict, write protect
// - External master accesses internal space sync or async
// - INDEPENDENT_DMA_CHANNEL uses external release demand only when core off
module host_bus_arbiter
  import arb_pins_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     coreDisableStrap,
  input  wire logic                     dedicatedIrqMode,
  input  wire logic                     irqLowEdgeMode,
  input  wire logic                     irqMidEdgeMode,
  input  wire logic                     coreWantsBus,
  input  wire logic                     coreIackCycle,
  input  wire logic                     coreProgCycle,
  input  wire logic                     busCycleActive,
  input  wire logic                     internalReleaseDemand,
  input  wire arb_pins_pkg::dma_req_s   dmaReq,
  input  wire logic [2:0]               idmaCodeCfg,
  input  wire logic [2:0]               sdmaCodeCfg,
  input  wire logic [2:0]               irqCtrlLevel,
  input  wire logic                     csAutoAck,
  input  wire logic                     csAckNow,
  input  wire logic                     watchdogTimeout,
  input  wire logic                     addrConflict,
  input  wire logic                     writeProtectFault,
  input  wire logic                     irqTaken,
  input  wire logic                     mastershipRequestN_in,
  input  wire logic                     mastershipGrantN_in,
  input  wire logic                     mastershipTakenAckN_in,
  input  wire logic [2:0]               encodedIrqLevelN,
  input  wire logic                     autoVectorSelectN,
  input  wire logic                     transferAckN_in,
  input  wire logic                     releaseDemandN_in,
  input  wire logic                     busFaultN_in,
  input  wire logic                     addressStrobeN_in,
  input  wire logic [2:0]               cycleTypeCode_in,
  output arb_pins_pkg::pin_out_s        mastershipRequestN_out,
  output arb_pins_pkg::pin_out_s        mastershipGrantN_out,
  output arb_pins_pkg::pin_out_s        mastershipTakenAckN_out,
  output arb_pins_pkg::pin_out_s        transferAckN_out,
  output arb_pins_pkg::pin_out_s        releaseDemandN_out,
  output arb_pins_pkg::pin_out_s        busFaultN_out,
  output logic [2:0]                    cycleTypeCode_out,
  output logic                          cycleTypeCode_oe,
  output logic [2:0]                    irqOutLevelN,
  output logic                          irqOutLevelN_oe,
  output logic [2:0]                    pendingIrqLevel,
  output logic                          pendingAutoVector,
  output logic                          pendingExtAck,
  output logic                          idmaGranted,
  output logic                          sdmaGranted,
  output logic                          idmaReleaseSeen,
  output logic                          extCycleSeen
);
  import arb_pins_pkg::*;

  // Synchronised pin levels, active high after inversion
  logic [7:0] rawAsync;
  logic [7:0] syncd;
  logic       reqS;
  logic       grantS;
  logic       takenS;
  logic [2:0] lvlS;
  logic       releaseS;
  logic       strobeS;

  assign rawAsync = {~mastershipRequestN_in, ~mastershipGrantN_in, ~mastershipTakenAckN_in,
                     ~encodedIrqLevelN, ~releaseDemandN_in, ~addressStrobeN_in};

  sync_stage #(
    .WIDTH  (8),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .asyncIn  (rawAsync),
    .resetVal (8'h00),
    .syncOut  (syncd)
  );

  assign {reqS, grantS, takenS, lvlS, releaseS, strobeS} = syncd;

  // Strap taken while reset is held; only changes on a total reset
  logic coreOff_q;
  logic coreOff_d;

  always_comb begin
    coreOff_d = srst ? coreDisableStrap : coreOff_q;
  end

  always_ff @(posedge mclk) begin
    coreOff_q <= coreOff_d;
  end

  // Ownership
  owner_e owner_q;
  owner_e owner_d;
  logic   grantN_q;
  logic   grantN_d;
  logic   reqN_q;
  logic   reqN_d;
  logic   takenN_q;
  logic   takenN_d;
  logic   dmaReqAny;
  logic   idmaRelease;

  assign dmaReqAny   = dmaReq.independent_dma_channel | dmaReq.serial_dma_channel;
  assign idmaRelease = coreOff_q ? releaseS : internalReleaseDemand;

  always_comb begin
    owner_d  = owner_q;
    grantN_d = 1'b1;
    reqN_d   = 1'b1;
    case (owner_q)
      OWN_CORE: begin
        if (coreOff_q) begin
          if (dmaReqAny) begin
            reqN_d = 1'b0;
          end
          if (dmaReqAny && grantS && !takenS && !busCycleActive) begin
            owner_d = dmaReq.serial_dma_channel ? OWN_SERIAL_DMA_CHANNEL : OWN_INDEPENDENT_DMA_CHANNEL;
          end
        end else if (reqS && !takenS) begin
          owner_d = OWN_GRANT;
        end else if (dmaReqAny && !coreWantsBus && !busCycleActive) begin
          owner_d = dmaReq.serial_dma_channel ? OWN_SERIAL_DMA_CHANNEL : OWN_INDEPENDENT_DMA_CHANNEL;
        end
      end
      OWN_GRANT: begin
        grantN_d = 1'b0;
        if (takenS && !busCycleActive) begin
          owner_d = OWN_EXT;
        end else if (!reqS) begin
          owner_d = OWN_CORE;
        end
      end
      OWN_EXT: begin
        // External master keeps the bus while it holds grant-ack
        if (!takenS) begin
          owner_d = OWN_CORE;
        end
      end
      OWN_INDEPENDENT_DMA_CHANNEL: begin
        reqN_d = coreOff_q ? 1'b0 : 1'b1;
        if (dmaReq.serial_dma_channel && !busCycleActive) begin
          owner_d = OWN_SERIAL_DMA_CHANNEL;
        end else if ((!dmaReq.independent_dma_channel || idmaRelease) && !busCycleActive) begin
          owner_d = OWN_CORE;
        end
      end
      OWN_SERIAL_DMA_CHANNEL: begin
        reqN_d = coreOff_q ? 1'b0 : 1'b1;
        if (!dmaReq.serial_dma_channel && !busCycleActive) begin
          owner_d = dmaReq.independent_dma_channel && !idmaRelease ? OWN_INDEPENDENT_DMA_CHANNEL : OWN_CORE;
        end
      end
      default: begin
        owner_d = OWN_CORE;
      end
    endcase
    // Grant-ack driven low continuously for either DMA owner
    takenN_d = !(owner_d == OWN_INDEPENDENT_DMA_CHANNEL || owner_d == OWN_SERIAL_DMA_CHANNEL);
    if (srst) begin
      owner_d  = OWN_CORE;
      grantN_d = mastershipRequestN_in;
      reqN_d   = 1'b1;
      takenN_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    owner_q  <= owner_d;
    grantN_q <= grantN_d;
    reqN_q   <= reqN_d;
    takenN_q <= takenN_d;
  end

  // Interrupt inputs
  logic [2:0] lvlPrev_q;
  logic [2:0] lvlPrev_d;
  logic [2:0] latched_q;
  logic [2:0] latched_d;
  logic [2:0] pend_q;
  logic [2:0] pend_d;
  logic [2:0] level;

  always_comb begin
    lvlPrev_d = lvlS;
    latched_d = latched_q;
    level     = IRQ_LEVEL_NONE;
    // Edge catches survive a same-cycle acknowledge
    if (irqTaken) begin
      latched_d = 3'h0;
    end
    // Edges only count as requests in dedicated mode; encoded levels would leave stale catches
    if (dedicatedIrqMode && lvlS[2] && !lvlPrev_q[2]) begin
      latched_d[2] = 1'b1;
    end
    if (dedicatedIrqMode && irqLowEdgeMode && lvlS[0] && !lvlPrev_q[0]) begin
      latched_d[0] = 1'b1;
    end
    if (dedicatedIrqMode && irqMidEdgeMode && lvlS[1] && !lvlPrev_q[1]) begin
      latched_d[1] = 1'b1;
    end
    if (dedicatedIrqMode) begin
      if (latched_q[2]) begin
        level = IRQ_LEVEL_TOP;
      end else if (irqMidEdgeMode ? latched_q[1] : lvlS[1]) begin
        level = IRQ_LEVEL_MID;
      end else if (irqLowEdgeMode ? latched_q[0] : lvlS[0]) begin
        level = IRQ_LEVEL_LOW;
      end
    end else begin
      level = lvlS;
    end
    pend_d = level;
    if (srst) begin
      lvlPrev_d = 3'h0;
      latched_d = 3'h0;
      pend_d    = IRQ_LEVEL_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    lvlPrev_q <= lvlPrev_d;
    latched_q <= latched_d;
    pend_q    <= pend_d;
  end

  // Cycle codes, acknowledges, fault, outward interrupt levels
  logic [2:0] code_q;
  logic [2:0] code_d;
  logic       codeOe_q;
  logic       codeOe_d;
  logic       ackN_q;
  logic       ackN_d;
  logic       ackOe_q;
  logic       ackOe_d;
  logic       faultN_q;
  logic       faultN_d;
  logic [2:0] iout_q;
  logic [2:0] iout_d;
  logic       auto_vector_select_q;
  logic       auto_vector_select_d;
  logic       extAck_q;
  logic       extAck_d;
  logic       relOe_q;
  logic       relOe_d;
  logic       extSeen_q;
  logic       extSeen_d;
  logic       imMaster;

  assign imMaster = (owner_q == OWN_CORE && !coreOff_q) || owner_q == OWN_INDEPENDENT_DMA_CHANNEL || owner_q == OWN_SERIAL_DMA_CHANNEL;

  always_comb begin
    codeOe_d = imMaster;
    case (owner_q)
      OWN_INDEPENDENT_DMA_CHANNEL: code_d = idmaCodeCfg;
      OWN_SERIAL_DMA_CHANNEL: code_d = sdmaCodeCfg;
      default:  code_d = coreIackCycle ? CORE_CODE_IACK : (coreProgCycle ? CORE_CODE_PROG : CORE_CODE_DATA);
    endcase
    ackOe_d  = csAutoAck;
    ackN_d   = !(csAutoAck && csAckNow);
    faultN_d = !(watchdogTimeout || addrConflict || writeProtectFault);
    iout_d   = ~irqCtrlLevel;
    // Autovector only counts inside an acknowledge cycle; pin is an output when core off
    auto_vector_select_d   = !coreOff_q && coreIackCycle && !autoVectorSelectN;
    extAck_d = !transferAckN_in && !busFaultN_in ? 1'b0 : !transferAckN_in;
    // Release demand: open-drain output, also watched as input when core off
    relOe_d  = dmaReq.serial_dma_channel && owner_q != OWN_SERIAL_DMA_CHANNEL;
    // External master cycle into internal space, clocked or not
    extSeen_d = owner_q == OWN_EXT && strobeS && cycleTypeCode_in != 3'h0;
    if (srst) begin
      codeOe_d  = 1'b0;
      code_d    = 3'h0;
      ackOe_d   = 1'b0;
      ackN_d    = 1'b1;
      faultN_d  = 1'b1;
      iout_d    = 3'h7;
      auto_vector_select_d    = 1'b0;
      extAck_d  = 1'b0;
      relOe_d   = 1'b0;
      extSeen_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    code_q    <= code_d;
    codeOe_q  <= codeOe_d;
    ackN_q    <= ackN_d;
    ackOe_q   <= ackOe_d;
    faultN_q  <= faultN_d;
    iout_q    <= iout_d;
    auto_vector_select_q    <= auto_vector_select_d;
    extAck_q  <= extAck_d;
    relOe_q   <= relOe_d;
    extSeen_q <= extSeen_d;
  end

  // Request and grant pins swap direction with the core off
  assign mastershipRequestN_out  = '{drive: 1'b0, oe: !reqN_q};
  assign mastershipGrantN_out    = '{drive: grantN_q, oe: !coreOff_q};
  assign mastershipTakenAckN_out = '{drive: 1'b0, oe: !takenN_q};
  assign transferAckN_out        = '{drive: ackN_q, oe: ackOe_q};
  assign releaseDemandN_out      = '{drive: 1'b0, oe: relOe_q};
  assign busFaultN_out           = '{drive: 1'b0, oe: !faultN_q};
  assign cycleTypeCode_out       = code_q;
  assign cycleTypeCode_oe        = codeOe_q;
  assign irqOutLevelN            = iout_q;
  assign irqOutLevelN_oe         = coreOff_q;
  assign pendingIrqLevel         = pend_q;
  assign pendingAutoVector       = auto_vector_select_q;
  assign pendingExtAck           = extAck_q;
  assign idmaGranted             = owner_q == OWN_INDEPENDENT_DMA_CHANNEL;
  assign sdmaGranted             = owner_q == OWN_SERIAL_DMA_CHANNEL;
  assign idmaReleaseSeen         = idmaRelease;
  assign extCycleSeen            = extSeen_q;
endmodule

// [verilog/arb_pins_pkg.sv]
package arb_pins_pkg;

  // Cycle-type codes driven while the on-chip core is master
  localparam logic [2:0] CORE_CODE_DATA  = 3'h5;
  localparam logic [2:0] CORE_CODE_PROG  = 3'h6;
  localparam logic [2:0] CORE_CODE_IACK  = 3'h7;
  localparam logic [2:0] IRQ_LEVEL_NONE  = 3'h0;
  localparam logic [2:0] IRQ_LEVEL_LOW   = 3'h1;
  localparam logic [2:0] IRQ_LEVEL_MID   = 3'h6;
  localparam logic [2:0] IRQ_LEVEL_TOP   = 3'h7;
  localparam int         SYNC_STAGES     = 2;
  localparam logic       RST_CORE_OFF    = 1'b0;

  typedef enum logic [4:0] {
    OWN_CORE  = 5'b00001,
    OWN_GRANT = 5'b00010,
    OWN_EXT   = 5'b00100,
    OWN_INDEPENDENT_DMA_CHANNEL  = 5'b01000,
    OWN_SERIAL_DMA_CHANNEL  = 5'b10000
  } owner_e;

  // One open-drain or two-way pin, seen from the design
  typedef struct packed {
    logic drive;
    logic oe;
  } pin_out_s;

  // Pending requests from the DMA channels
  typedef struct packed {
    logic independent_dma_channel;
    logic serial_dma_channel;
  } dma_req_s;

endpackage

// [verilog/sync_stage.sv]
`timescale 1ns/100ps
module sync_stage #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetVal,
  output logic      [WIDTH-1:0] syncOut
);
  logic [STAGES-1:0][WIDTH-1:0] chain_q;
  logic [STAGES-1:0][WIDTH-1:0] chain_d;

  // Only the next stage reads each stage, so metastability never fans out
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], asyncIn};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      chain_q <= {STAGES{resetVal}};
    end else begin
      chain_q <= chain_d;
    end
  end

  assign syncOut = chain_q[STAGES-1];
endmodule

// [bench/host_bus_arbiter_asserts.sv]
`timescale 1ns/100ps
module host_bus_arbiter_asserts
  import arb_pins_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire logic                   mastershipRequestN_in,
  input wire logic                   mastershipTakenAckN_in,
  input wire logic [2:0]             idmaCodeCfg,
  input wire logic                   watchdogTimeout,
  input wire logic                   addrConflict,
  input wire logic                   writeProtectFault,
  input wire logic                   csAutoAck,
  input wire arb_pins_pkg::pin_out_s mastershipGrantN_out,
  input wire arb_pins_pkg::pin_out_s mastershipTakenAckN_out,
  input wire arb_pins_pkg::pin_out_s transferAckN_out,
  input wire arb_pins_pkg::pin_out_s busFaultN_out,
  input wire logic [2:0]             cycleTypeCode_out,
  input wire logic                   cycleTypeCode_oe,
  input wire logic                   idmaGranted,
  input wire logic                   sdmaGranted
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_reset_grant: assert property (disable iff (1'h0)
    $past(srst) && srst |-> mastershipGrantN_out.drive == $past(mastershipRequestN_in)) else $error("grant not mirroring");
  chk_grant_asserts: assert property (
    (!mastershipRequestN_in && mastershipTakenAckN_in && mastershipGrantN_out.oe)[*6] |-> !mastershipGrantN_out.drive)
    else $error("grant missing");
  chk_ack_dma: assert property ($rose(idmaGranted) || $rose(sdmaGranted) |-> ##[0:2]
    (mastershipTakenAckN_out.oe && !mastershipTakenAckN_out.drive)) else $error("grant-ack not driven");
  chk_ack_no_gap: assert property ((idmaGranted && mastershipTakenAckN_out.oe) ##1 sdmaGranted |->
    mastershipTakenAckN_out.oe ##1 mastershipTakenAckN_out.oe) else $error("grant-ack gap");
  chk_dma_codes: assert property (idmaGranted && $past(idmaGranted) && $past(idmaGranted, 2)
    && cycleTypeCode_oe && $stable(idmaCodeCfg) |-> cycleTypeCode_out == idmaCodeCfg) else $error("dma code wrong");
  chk_code_release: assert property (
    (!mastershipTakenAckN_in && !idmaGranted && !sdmaGranted)[*4] |-> !cycleTypeCode_oe) else $error("code driven");
  chk_fault_drive: assert property (watchdogTimeout || addrConflict || writeProtectFault |=>
    busFaultN_out.oe && !busFaultN_out.drive) else $error("bus fault not driven");
  chk_ack_gen: assert property (!csAutoAck && $past(!csAutoAck) |-> !transferAckN_out.oe)
    else $error("transfer ack driven");
  cover property ($rose(sdmaGranted));
  cover property ($fell(mastershipGrantN_out.drive));
  cover property (cycleTypeCode_oe && idmaGranted);
endmodule
bind host_bus_arbiter host_bus_arbiter_asserts i_chk (.*);

// [bench/ext_bus_master.sv]
`timescale 1ns/100ps
module ext_bus_master (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic wantBus,
  input  wire logic slow,
  input  wire logic reqPinN,
  input  wire logic grantPinN,
  input  wire logic ackPinN,
  output logic      reqN = 1'h1,
  output logic      ackN = 1'h1,
  output logic      grantN
);
  logic [1:0] waitCnt = 2'h0;
  always @(posedge mclk) begin
    if (!wantBus) begin
      reqN <= 1'h1;
      ackN <= 1'h1;
      waitCnt <= 2'h0;
    end else if (ackN) begin
      reqN <= 1'h0;
      // Never take the bus while another master holds grant-ack
      if (!grantPinN && ackPinN && !srst) begin
        waitCnt <= waitCnt + 2'h1;
        if (!slow || waitCnt == 2'h3) begin
          ackN <= 1'h0;
          reqN <= 1'h1;
        end
      end
    end
  end
  // Core-off arbiter grants whoever pulls the request line
  assign grantN = reqPinN;
endmodule

// [bench/host_bus_arbiter_tb_top.sv]
`timescale 1ns/100ps
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", s, e, g); end end
module host_bus_arbiter_tb_top;
  import arb_pins_pkg::*;
  typedef struct packed {logic [3:0] sel; logic [7:0] val;} note_s;
  logic       mclk = '0, srst = '1, coreDisableStrap = '0, dedicatedIrqMode = '0, irqLowEdgeMode = '0;
  logic       irqMidEdgeMode = '0, coreWantsBus = '0, coreIackCycle = '0, coreProgCycle = '0, busCycleActive = '0;
  logic       internalReleaseDemand = '0, csAutoAck = '0, csAckNow = '0, watchdogTimeout = '0, addrConflict = '0;
  logic       writeProtectFault = '0, irqTaken = '0, autoVectorSelectN = '1, transferAckN_in = '1, busFaultN_in = '1;
  logic       addressStrobeN_in = '1, want = '1, slow = '0, extReqN, extAckN, extGrantN;
  logic       mastershipRequestN_in, mastershipGrantN_in, mastershipTakenAckN_in, releaseDemandN_in;
  logic [2:0] idmaCodeCfg = '0, sdmaCodeCfg = '0, irqCtrlLevel = '0, encodedIrqLevelN = '1, cycleTypeCode_in = '0;
  logic [2:0] cycleTypeCode_out, irqOutLevelN, pendingIrqLevel, lv;
  logic       cycleTypeCode_oe, irqOutLevelN_oe, pendingAutoVector, pendingExtAck, idmaGranted, sdmaGranted;
  logic       idmaReleaseSeen, extCycleSeen;
  logic [2:0] codes [3] = '{CORE_CODE_DATA, CORE_CODE_PROG, CORE_CODE_IACK};
  logic [2:0] pinT [4] = '{3'h6, 3'h4, 3'h0, 3'h4};
  logic [2:0] lvlT [4] = '{3'h1, 3'h6, 3'h7, 3'h7};
  dma_req_s   dmaReq = '0;
  pin_out_s   mastershipRequestN_out, mastershipGrantN_out, mastershipTakenAckN_out, transferAckN_out;
  pin_out_s   releaseDemandN_out, busFaultN_out;
  note_s      q[$];
  note_s      nt;
  int         n_fail = 0, n_checks = 0, cyc = 0, seed = 73;
  event       look;
  string      nm [12] = '{"grant", "grantOe", "ackOe", "code", "pending", "independent_dma_channel", "serial_dma_channel", "faultOe", "irqOut",
                          "reqOe", "tackOe", "relAvecAck"};

  always #50 mclk = ~mclk;
  host_bus_arbiter i_dut (.*);
  ext_bus_master i_ext (.mclk(mclk), .srst(srst), .wantBus(want), .slow(slow), .reqPinN(mastershipRequestN_in),
    .grantPinN(mastershipGrantN_in), .ackPinN(mastershipTakenAckN_in), .reqN(extReqN), .ackN(extAckN),
    .grantN(extGrantN));
  // Open-drain and two-way pins resolved from every party
  assign mastershipRequestN_in = extReqN & ~mastershipRequestN_out.oe;
  assign mastershipTakenAckN_in = extAckN & (~mastershipTakenAckN_out.oe | mastershipTakenAckN_out.drive);
  assign mastershipGrantN_in = mastershipGrantN_out.oe ? mastershipGrantN_out.drive : extGrantN;
  assign releaseDemandN_in = ~releaseDemandN_out.oe;

  function automatic logic [7:0] obs(input int s);
    case (s)
      0: return {7'h0, mastershipGrantN_out.drive};
      1: return {7'h0, mastershipGrantN_out.oe};
      2: return {7'h0, mastershipTakenAckN_out.oe};
      3: return {4'h0, cycleTypeCode_oe, cycleTypeCode_out};
      4: return {5'h0, pendingIrqLevel};
      5: return {7'h0, idmaGranted};
      6: return {7'h0, sdmaGranted};
      7: return {7'h0, busFaultN_out.oe};
      8: return {4'h0, irqOutLevelN_oe, irqOutLevelN};
      9: return {7'h0, mastershipRequestN_out.oe};
      11: return {5'h0, releaseDemandN_out.oe, pendingAutoVector, pendingExtAck};
      default: return {7'h0, transferAckN_out.oe};
    endcase
  endfunction
  task automatic note(input int s, input logic [7:0] v);
    q.push_back('{s[3:0], v});
    -> look;
  endtask
  // Bounded wait, then the note is judged whatever was reached
  task automatic waitFor(input int s, input logic [7:0] v);
    int n;
    n = 0;
    while (obs(s) !== v && n < 60) begin
      @(negedge mclk);
      n++;
    end
    note(s, v);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(look) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      `CHK(nm[nt.sel], nt.val, obs(nt.sel))
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    step(5);
    @(negedge mclk) note(0, 8'h0);
    @(posedge mclk) want <= '0;
    step(2);
    srst <= '0;
    @(negedge mclk) note(0, 8'h1);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk) slow <= i[0];
      want <= '1;
      waitFor(0, 8'h0);
      waitFor(0, 8'h1);
      @(posedge mclk) want <= '0;
      step(4);
    end
    $display("arbitration test done");
    @(posedge mclk) idmaCodeCfg <= 3'($random(seed));
    sdmaCodeCfg <= 3'($random(seed));
    dmaReq.independent_dma_channel <= '1;
    waitFor(5, 8'h1);
    waitFor(2, 8'h1);
    step(3);
    @(negedge mclk) note(3, {5'h01, idmaCodeCfg});
    @(posedge mclk) dmaReq.serial_dma_channel <= '1;
    waitFor(6, 8'h1);
    note(2, 8'h1);
    step(3);
    @(negedge mclk) note(3, {5'h01, sdmaCodeCfg});
    @(posedge mclk) dmaReq <= '0;
    waitFor(2, 8'h0);
    coreWantsBus <= '1;
    busCycleActive <= '1;
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) coreProgCycle <= (k == 1);
      coreIackCycle <= (k == 2);
      step(3);
      @(negedge mclk) note(3, {5'h01, codes[k]});
    end
    @(posedge mclk) {busCycleActive, coreWantsBus, coreIackCycle} <= 3'h0;
    $display("dma and code test done");
    lv = 3'($random(seed));
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) encodedIrqLevelN <= ~(lv ^ 3'(i));
      waitFor(4, {5'h0, lv ^ 3'(i)});
    end
    @(posedge mclk) dedicatedIrqMode <= '1;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) encodedIrqLevelN <= pinT[k];
      step(4);
      waitFor(4, {5'h0, lvlT[k]});
    end
    @(posedge mclk) irqTaken <= '1;
    @(posedge mclk) irqTaken <= '0;
    waitFor(4, 8'h6);
    @(posedge mclk) encodedIrqLevelN <= 3'h7;
    waitFor(4, 8'h0);
    // Edge mode: a short mid-level pulse must stay pending until taken
    @(posedge mclk) irqMidEdgeMode <= '1;
    encodedIrqLevelN <= 3'h5;
    step(3);
    @(posedge mclk) encodedIrqLevelN <= 3'h7;
    step(4);
    @(negedge mclk) note(4, 8'h6);
    @(posedge mclk) irqTaken <= '1;
    @(posedge mclk) irqTaken <= '0;
    waitFor(4, 8'h0);
    $display("interrupt test done");
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) {writeProtectFault, addrConflict, watchdogTimeout} <= 3'h1 << k;
      waitFor(7, 8'h1);
      @(posedge mclk) {writeProtectFault, addrConflict, watchdogTimeout} <= 3'h0;
      waitFor(7, 8'h0);
    end
    @(posedge mclk) {csAutoAck, csAckNow} <= 2'h3;
    step(3);
    @(negedge mclk) note(10, 8'h1);
    @(posedge mclk) {csAutoAck, csAckNow} <= 2'h0;
    waitFor(10, 8'h0);
    @(posedge mclk) coreIackCycle <= '1;
    autoVectorSelectN <= '0;
    transferAckN_in <= '0;
    step(2);
    @(negedge mclk) note(11, 8'h03);
    @(posedge mclk) coreIackCycle <= '0;
    autoVectorSelectN <= '1;
    transferAckN_in <= '1;
    step(2);
    @(negedge mclk) note(11, 8'h00);
    $display("fault test done");
    @(posedge mclk) srst <= '1;
    coreDisableStrap <= '1;
    irqCtrlLevel <= 3'($random(seed));
    step(8);
    srst <= '0;
    step(3);
    @(negedge mclk) note(1, 8'h0);
    waitFor(8, {5'h01, ~irqCtrlLevel});
    @(posedge mclk) dmaReq.independent_dma_channel <= '1;
    waitFor(9, 8'h1);
    waitFor(5, 8'h1);
    @(posedge mclk) dmaReq <= '0;
    step(4);
    $display("core-off test done");
    print_verdict();
  end
endmodule
